// [inc/ebi_consts.svh]
`ifndef EBI_CONSTS_SVH
`define EBI_CONSTS_SVH

`define EBI_AW             16
`define EBI_DW             16
`define EBI_INT_PROG_TOP   16'h0FFF
`define EBI_GLOBAL_WINDOW_SIZE_REG_W         8
`define EBI_GLOBAL_WINDOW_SIZE_REG_RST       8'h00
`define EBI_GLOBAL_WINDOW_SIZE_REG_ADDR      16'h0005
`define EBI_GLOBAL_MAX     16'h8000
`define EBI_SYNC_STAGES    3

`endif

// [inc/ebi_pkg.sv]
package ebi_pkg;

    typedef enum logic [1:0] {
        EBI_SP_DATA,
        EBI_SP_PROG,
        EBI_SP_IO
    } ebi_space_t;

    typedef enum logic [2:0] {
        EBI_IDLE,
        EBI_ADDR,
        EBI_TRANSFER_STROBE_N,
        EBI_HOLD
    } ebi_state_t;

endpackage : ebi_pkg

// [rtl/ebi_sync.sv]
`timescale 1ns/1ps
`include "ebi_consts.svh"

module ebi_sync
    import ebi_pkg::*;
(
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic resetn_i,
    // pin in, filtered level out
    input  wire logic pin_i,
    output logic      level_o
);

    typedef struct packed {
        logic [2:0] sh;
        logic       lvl;
    } ebi_sync_st_t;

    ebi_sync_st_t st_ff;
    ebi_sync_st_t nxt_st;

    // level changes only when stages two and three agree
    always_comb begin
        nxt_st    = st_ff;
        nxt_st.sh = {st_ff.sh[1:0], pin_i};
        if (st_ff.sh[1] == st_ff.sh[2]) begin
            nxt_st.lvl = st_ff.sh[2];
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_ff <= '{sh: 3'h7, lvl: 1'b1};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign level_o = st_ff.lvl;

endmodule : ebi_sync

// [rtl/ebi_core.sv]
// How it works
// - 16-bit data lines and 16-bit address out
// - exactly one space select per external access
// - read/write direction and strobe timing outputs
// - internal program or ready memory: no waits
// - ready low stretches cycle, ready high ends
// - program and data share one bus
// - data space covers full 64K words
// - program above first 4K goes external
// - 8-bit global register sets global window
// - register value sets window size
// - operand in window asserts bus request
// - global cycle waits for ready from arbiter
// - hold floats address, data and controls
// - default mode suspends core during hold
// - concurrent mode runs internally, stalls on bus
`timescale 1ns/1ps
`include "ebi_consts.svh"

module ebi_core
    import ebi_pkg::*;
(
    // clock and reset
    input  wire logic                   mclk_i,
    input  wire logic                   resetn_i,
    // core request side
    input  wire logic                   req_i,
    input  wire logic                   req_we_i,
    input  wire logic [1:0]             req_space_i,
    input  wire logic [`EBI_AW-1:0]     req_addr_i,
    input  wire logic [`EBI_DW-1:0]     req_wdata_i,
    input  wire logic                   concurrent_mode_i,
    output logic                        done_o,
    output logic [`EBI_DW-1:0]          rdata_o,
    output logic                        core_stall_o,
    output logic [`EBI_GLOBAL_WINDOW_SIZE_REG_W-1:0]      global_window_size_reg_o,
    // external pins
    input  wire logic [`EBI_DW-1:0]     ext_data_lines_i,
    output logic [`EBI_DW-1:0]          ext_data_lines_o,
    output logic                        ext_data_lines_oe_o,
    output logic [`EBI_AW-1:0]          ext_address_lines_o,
    output logic                        ext_ctrl_oe_o,
    output logic                        data_space_select_n_o,
    output logic                        program_space_select_n_o,
    output logic                        io_space_select_n_o,
    output logic                        rd_wr_n_o,
    output logic                        transfer_strobe_n_o,
    input  wire logic                   ready_i,
    output logic                        shared_bus_request_n_o,
    input  wire logic                   hold_n_i,
    output logic                        bus_takeover_ack_n_o
);

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic ready_s;
    logic hold_n_s;

    ebi_sync u_sync_ready (
        .mclk_i    (mclk_i),
        .resetn_i  (resetn_i),
        .pin_i     (ready_i),
        .level_o   (ready_s)
    );

    ebi_sync u_sync_hold (
        .mclk_i    (mclk_i),
        .resetn_i  (resetn_i),
        .pin_i     (hold_n_i),
        .level_o   (hold_n_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        ebi_state_t             fsm;
        logic [`EBI_AW-1:0]     addr;
        logic [`EBI_DW-1:0]     wdata;
        logic [`EBI_DW-1:0]     rdata;
        logic [`EBI_GLOBAL_WINDOW_SIZE_REG_W-1:0] global_window_size_reg;
        logic                   we;
        logic                   ds_n;
        logic                   ps_n;
        logic                   is_n;
        logic                   transfer_strobe_n_n;
        logic                   rw;
        logic                   doe;
        logic                   coe;
        logic                   br_n;
        logic                   ack_n;
        logic                   done;
        logic                   stall;
    } ebi_st_t;

    ebi_st_t st_ff;
    ebi_st_t nxt_st;

    logic                   internal_hit;
    logic                   global_window_size_reg_hit;
    logic                   in_window;
    logic [`EBI_AW:0]       win_span;

    // global window sits at top of data space, size from register
    always_comb begin
        win_span  = {1'b0, st_ff.global_window_size_reg, 8'h00};
        if (win_span > {1'b0, `EBI_GLOBAL_MAX}) begin
            win_span = {1'b0, `EBI_GLOBAL_MAX};
        end
        in_window = (req_space_i == 2'(EBI_SP_DATA)) && (win_span != 17'h00000)
                    && ({1'b0, req_addr_i} >= (17'h10000 - win_span));
    end

    assign internal_hit = (req_space_i == 2'(EBI_SP_PROG))
                          && (req_addr_i <= `EBI_INT_PROG_TOP);
    assign global_window_size_reg_hit     = (req_space_i == 2'(EBI_SP_DATA))
                          && (req_addr_i == `EBI_GLOBAL_WINDOW_SIZE_REG_ADDR);

    ////////////////////////////////////////////////////////////////////////////
    // bus cycle sequencer

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.done  = 1'b0;
        nxt_st.stall = 1'b0;
        case (st_ff.fsm)
            EBI_IDLE: begin
                if (!hold_n_s) begin
                    nxt_st.fsm   = EBI_HOLD;
                    nxt_st.coe   = 1'b0;
                    nxt_st.doe   = 1'b0;
                    nxt_st.stall = !concurrent_mode_i || req_i;
                end else if (req_i && (internal_hit || global_window_size_reg_hit)) begin
                    nxt_st.done = 1'b1;
                    if (global_window_size_reg_hit && req_we_i) begin
                        nxt_st.global_window_size_reg = req_wdata_i[`EBI_GLOBAL_WINDOW_SIZE_REG_W-1:0];
                    end
                    nxt_st.rdata = global_window_size_reg_hit ? {8'h00, st_ff.global_window_size_reg} : 16'h0000;
                end else if (req_i) begin
                    nxt_st.fsm   = EBI_ADDR;
                    nxt_st.addr  = req_addr_i;
                    nxt_st.wdata = req_wdata_i;
                    nxt_st.we    = req_we_i;
                    nxt_st.rw    = !req_we_i;
                    nxt_st.doe   = req_we_i;
                    nxt_st.ds_n  = !(req_space_i == 2'(EBI_SP_DATA));
                    nxt_st.ps_n  = !(req_space_i == 2'(EBI_SP_PROG));
                    nxt_st.is_n  = !(req_space_i == 2'(EBI_SP_IO));
                    nxt_st.br_n  = !in_window;
                    nxt_st.stall = 1'b1;
                end
            end
            EBI_ADDR: begin
                nxt_st.fsm    = EBI_TRANSFER_STROBE_N;
                nxt_st.transfer_strobe_n_n = 1'b0;
                nxt_st.stall  = 1'b1;
            end
            EBI_TRANSFER_STROBE_N: begin
                if (ready_s) begin
                    nxt_st.fsm    = EBI_IDLE;
                    nxt_st.transfer_strobe_n_n = 1'b1;
                    nxt_st.ds_n   = 1'b1;
                    nxt_st.ps_n   = 1'b1;
                    nxt_st.is_n   = 1'b1;
                    nxt_st.br_n   = 1'b1;
                    nxt_st.rw     = 1'b1;
                    nxt_st.doe    = 1'b0;
                    nxt_st.done   = 1'b1;
                    nxt_st.rdata  = st_ff.we ? 16'h0000 : ext_data_lines_i;
                end else begin
                    nxt_st.stall = 1'b1;
                end
            end
            EBI_HOLD: begin
                nxt_st.ack_n = 1'b0;
                nxt_st.stall = !concurrent_mode_i || req_i;
                if (req_i && internal_hit && concurrent_mode_i) begin
                    nxt_st.done  = 1'b1;
                    nxt_st.stall = 1'b0;
                end
                if (hold_n_s && !st_ff.ack_n) begin
                    nxt_st.fsm   = EBI_IDLE;
                    nxt_st.ack_n = 1'b1;
                    nxt_st.coe   = 1'b1;
                end
            end
            default: begin
                nxt_st.fsm = EBI_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_ff <= '{fsm: EBI_IDLE, addr: 16'h0000, wdata: 16'h0000,
                       rdata: 16'h0000, global_window_size_reg: `EBI_GLOBAL_WINDOW_SIZE_REG_RST, we: 1'b0,
                       ds_n: 1'b1, ps_n: 1'b1, is_n: 1'b1, transfer_strobe_n_n: 1'b1,
                       rw: 1'b1, doe: 1'b0, coe: 1'b1, br_n: 1'b1,
                       ack_n: 1'b1, done: 1'b0, stall: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign done_o                   = st_ff.done;
    assign rdata_o                  = st_ff.rdata;
    assign core_stall_o             = st_ff.stall;
    assign global_window_size_reg_o = st_ff.global_window_size_reg;
    assign ext_data_lines_o         = st_ff.wdata;
    assign ext_data_lines_oe_o      = st_ff.doe;
    assign ext_address_lines_o      = st_ff.addr;
    assign ext_ctrl_oe_o            = st_ff.coe;
    assign data_space_select_n_o    = st_ff.ds_n;
    assign program_space_select_n_o = st_ff.ps_n;
    assign io_space_select_n_o      = st_ff.is_n;
    assign rd_wr_n_o                = st_ff.rw;
    assign transfer_strobe_n_o      = st_ff.transfer_strobe_n_n;
    assign shared_bus_request_n_o   = st_ff.br_n;
    assign bus_takeover_ack_n_o     = st_ff.ack_n;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    property p_one_space;
        @(posedge mclk_i) disable iff (!resetn_i)
        !st_ff.transfer_strobe_n_n |-> $onehot({!st_ff.ds_n, !st_ff.ps_n, !st_ff.is_n});
    endproperty
    a_one_space: assert property (p_one_space) else $error("space select not one-hot");

    property p_wait;
        @(posedge mclk_i) disable iff (!resetn_i)
        (st_ff.fsm == EBI_TRANSFER_STROBE_N && !ready_s) |=> !st_ff.transfer_strobe_n_n;
    endproperty
    a_wait: assert property (p_wait) else $error("strobe ended without ready");

    property p_finish;
        @(posedge mclk_i) disable iff (!resetn_i)
        (st_ff.fsm == EBI_TRANSFER_STROBE_N && ready_s) |=> (st_ff.transfer_strobe_n_n && st_ff.done);
    endproperty
    a_finish: assert property (p_finish) else $error("cycle did not end on ready");

    property p_float;
        @(posedge mclk_i) disable iff (!resetn_i)
        !st_ff.ack_n |-> (!st_ff.coe && !st_ff.doe);
    endproperty
    a_float: assert property (p_float) else $error("ack while driving bus");

    property p_ack_rise;
        @(posedge mclk_i) disable iff (!resetn_i)
        $fell(st_ff.ack_n) |-> $past(st_ff.fsm) == EBI_HOLD;
    endproperty
    a_ack_rise: assert property (p_ack_rise) else $error("ack outside hold");

    property p_no_new;
        @(posedge mclk_i) disable iff (!resetn_i)
        (st_ff.fsm == EBI_IDLE && !hold_n_s) |=> st_ff.fsm == EBI_HOLD;
    endproperty
    a_no_new: assert property (p_no_new) else $error("access started in hold");

    property p_internal;
        @(posedge mclk_i) disable iff (!resetn_i)
        (st_ff.fsm == EBI_IDLE && hold_n_s && req_i && internal_hit) |=> st_ff.done;
    endproperty
    a_internal: assert property (p_internal) else $error("internal access waited");

    property p_suspend;
        @(posedge mclk_i) disable iff (!resetn_i)
        (st_ff.fsm == EBI_HOLD && !concurrent_mode_i && hold_n_s == 1'b0) |=> st_ff.stall;
    endproperty
    a_suspend: assert property (p_suspend) else $error("core ran in suspended hold");

    property p_br;
        @(posedge mclk_i) disable iff (!resetn_i)
        (st_ff.fsm == EBI_IDLE && hold_n_s && req_i && !internal_hit && !global_window_size_reg_hit
         && in_window) |=> !st_ff.br_n;
    endproperty
    a_br: assert property (p_br) else $error("bus request missing");

    c_read:   cover property (@(posedge mclk_i) $rose(st_ff.done) && st_ff.rw);
    c_wait:   cover property (@(posedge mclk_i) !st_ff.transfer_strobe_n_n [*3]);
    c_hold:   cover property (@(posedge mclk_i) $fell(st_ff.ack_n));
    c_global: cover property (@(posedge mclk_i) $fell(st_ff.br_n));

endmodule : ebi_core

// [tb/ebi_mem_model.sv]
`timescale 1ns/1ps

module ebi_mem_model (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    // bus from the device
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        sel_n_i,
    input  wire logic        rd_wr_n_i,
    input  wire logic        strobe_n_i,
    input  wire logic [3:0]  wait_cfg_i,
    // answers to the device
    output logic      [15:0] rdata_o,
    output logic             ready_o
);
    logic [15:0] mem [0:255];
    logic [15:0] last_ff;
    logic [3:0]  cnt_ff;

    // slow part keeps ready low until its wait count has run
    assign ready_o = (wait_cfg_i == 4'h0) || (!strobe_n_i && cnt_ff >= wait_cfg_i);
    // released lines show the inverse of the last value
    assign rdata_o = (!sel_n_i && rd_wr_n_i && !strobe_n_i) ? mem[addr_i[7:0]] : ~last_ff;

    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_ff  <= 4'h0;
            last_ff <= 16'h0000;
        end else begin
            cnt_ff <= (strobe_n_i || cnt_ff == 4'hF) ? cnt_ff & {4{~strobe_n_i}} : cnt_ff + 4'h1;
            if (!strobe_n_i && !sel_n_i) begin
                last_ff <= rd_wr_n_i ? mem[addr_i[7:0]] : wdata_i;
                if (!rd_wr_n_i && ready_o)
                    mem[addr_i[7:0]] <= wdata_i;
            end
        end
    end
endmodule : ebi_mem_model

// [tb/tb_ebi_core.sv]
`timescale 1ns/1ps
`include "ebi_consts.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_ebi_core
    import ebi_pkg::*;
;
    logic mclk_i = 0, resetn_i = 0, req_i = 0, req_we_i = 0, conc = 0, hold_n = 1;
    logic [1:0] space = 2'h0;
    logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, dq_o, mdl_dq, bus, a_o;
    logic done, stall, dq_oe, coe, ds, ps, is_n, rw, transfer_strobe_n, ready, br, ack;
    logic [7:0] win;
    logic [3:0] wait_cfg = 4'h0;
    logic [2:0] sel_snap;
    logic rw_snap, br_snap;
    logic [15:0] a_snap, rd;
    int n_errors = 0, check_count = 0, cycles = 0, lat;

    always #5 mclk_i = ~mclk_i;
    assign bus = dq_oe ? dq_o : mdl_dq;

    ebi_core uut (.mclk_i(mclk_i), .resetn_i(resetn_i), .req_i(req_i), .req_we_i(req_we_i),
        .req_space_i(space), .req_addr_i(addr), .req_wdata_i(wdata),
        .concurrent_mode_i(conc), .done_o(done), .rdata_o(rdata), .core_stall_o(stall),
        .global_window_size_reg_o(win), .ext_data_lines_i(bus), .ext_data_lines_o(dq_o),
        .ext_data_lines_oe_o(dq_oe), .ext_address_lines_o(a_o), .ext_ctrl_oe_o(coe),
        .data_space_select_n_o(ds), .program_space_select_n_o(ps),
        .io_space_select_n_o(is_n), .rd_wr_n_o(rw), .transfer_strobe_n_o(transfer_strobe_n),
        .ready_i(ready), .shared_bus_request_n_o(br), .hold_n_i(hold_n),
        .bus_takeover_ack_n_o(ack));

    ebi_mem_model mdl (.mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(a_o), .wdata_i(bus),
        .sel_n_i(ds & ps & is_n), .rd_wr_n_i(rw), .strobe_n_i(transfer_strobe_n),
        .wait_cfg_i(wait_cfg), .rdata_o(mdl_dq), .ready_o(ready));

    task results;
        $display("checks=%0d mismatches=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            results();
        end
    end

    // raise a request, count edges until done or max, snapshot strobed cycle
    task go(input logic we, input logic [1:0] sp, input logic [15:0] a, input int max,
            input logic [15:0] d = 16'h5A5A);
        @(negedge mclk_i);
        req_i = 1'b1;
        req_we_i = we;
        space = sp;
        addr = a;
        wdata = a ^ d;
        sel_snap = 3'b111;
        br_snap = 1'b1;
        lat = 0;
        do begin
            @(posedge mclk_i);
            #1;
            lat++;
            if (!transfer_strobe_n) begin
                sel_snap = {ds, ps, is_n};
                rw_snap = rw;
                a_snap = a_o;
                br_snap = br;
            end
        end while (done !== 1'b1 && lat < max);
        rd = rdata;
    endtask : go

    task stop;
        @(negedge mclk_i);
        req_i = 1'b0;
        repeat (5) @(negedge mclk_i);
    endtask : stop

    task t_spaces;
        logic [2:0] exp_sel [0:2];
        logic [15:0] ad [0:2];
        exp_sel = '{3'b011, 3'b101, 3'b110};
        ad = '{16'hFF11, 16'h1022, 16'h0033};
        for (int i = 0; i < 3; i++) begin
            go(1'b1, i[1:0], ad[i], 60);
            stop();
            `CHK(lat >= 3 && lat <= 4, 1'b1)
            `CHK(sel_snap, exp_sel[i])
            `CHK(rw_snap, 1'b0)
            `CHK(a_snap, ad[i])
            go(1'b0, i[1:0], ad[i], 60);
            stop();
            `CHK(rw_snap, 1'b1)
            `CHK(rd, ad[i] ^ 16'h5A5A)
        end
        go(1'b0, 2'h1, 16'h0FFF, 60);
        stop();
        `CHK(lat <= 2, 1'b1)
        `CHK(sel_snap, 3'b111)
        wait_cfg = 4'h5;
        // let the synchronised ready fall before the slow access starts
        repeat (4) @(negedge mclk_i);
        go(1'b0, 2'h2, 16'h0033, 60);
        stop();
        `CHK(lat >= 8, 1'b1)
        `CHK(rd, 16'h0033 ^ 16'h5A5A)
        $display("test spaces done");
    endtask : t_spaces

    // win reg value, probe address, expected request level
    task t_window(input logic [7:0] v, input logic [15:0] a, input logic exp_br);
        wait_cfg = 4'h3;
        go(1'b1, 2'h0, 16'h0005, 60, {8'h00, v} ^ 16'h0005);
        stop();
        `CHK(win, v)
        go(1'b0, 2'h0, 16'h0005, 60);
        stop();
        `CHK(rd, {8'h00, v})
        go(1'b0, 2'h0, a, 60);
        stop();
        `CHK(br_snap, exp_br)
        `CHK(lat >= 6, 1'b1)
        $display("test window done");
    endtask : t_window

    task t_hold(input logic mode);
        conc = mode;
        @(negedge mclk_i);
        hold_n = 1'b0;
        repeat (8) @(negedge mclk_i);
        `CHK({ack, coe, dq_oe}, 3'b000)
        go(1'b0, 2'h1, 16'h0010, 8);
        `CHK({done, stall}, {mode, ~mode})
        if (mode)
            stop();
        if (mode)
            go(1'b0, 2'h0, 16'h0200, 8);
        `CHK({done, stall}, 2'b01)
        @(negedge mclk_i);
        hold_n = 1'b1;
        go(req_we_i, space, addr, 20);
        `CHK({done, ack, coe}, 3'b111)
        stop();
        $display("test hold done");
    endtask : t_hold

    task t_hold_mid;
        wait_cfg = 4'h6;
        go(1'b0, 2'h0, 16'h0201, 3);
        @(negedge mclk_i);
        hold_n = 1'b0;
        go(1'b0, 2'h0, 16'h0201, 30);
        `CHK({done, ack}, 2'b11)
        stop();
        `CHK(ack, 1'b0)
        hold_n = 1'b1;
        repeat (8) @(negedge mclk_i);
        `CHK({ack, coe}, 2'b11)
        $display("test hold mid done");
    endtask : t_hold_mid

    initial begin
        repeat (3) @(negedge mclk_i);
        `CHK({ack, transfer_strobe_n, ds, ps, is_n, br, rw, coe, dq_oe, done}, 10'h3FC)
        `CHK({win, stall}, 9'h000)
        resetn_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        t_spaces();
        t_window(8'h40, 16'hC000, 1'b0);
        t_window(8'h40, 16'hBFFF, 1'b1);
        t_window(8'hFF, 16'h7FFF, 1'b1);
        t_window(8'hFF, 16'h8000, 1'b0);
        t_hold(1'b1);
        t_hold(1'b0);
        t_hold_mid();
        results();
    end
endmodule : tb_ebi_core
